// [logic/cwd_config_decoder.sv]
// Configuration word decoder: captures the non-volatile word, decodes the static
// controls, runs the reset hold timer and the sleep wake logic, and exposes all of it
// on an Avalon-MM slave. Assumes the flash word is valid on the first clock after rst falls and the
// watchdog time-out arrives from a block on its own oscillator.
//
// The Avalon-MM interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "cwd_defines.svh"
module cwd_config_decoder
   import cwd_pkg::*;
#(
   parameter int HOLD_LONG_CYC = `CWD_HOLD_LONG_CYC,
   parameter int HOLD_SHORT_CYC = `CWD_HOLD_SHORT_CYC,
   parameter int PIN_W = 6
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [`CWD_WORD_W-1:0] nv_config_word,
   input wire logic shared_input_pin,
   input wire logic [PIN_W-1:0] input_pins,
   input wire logic watchdog_timeout,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [1:0] oscillator_select,
   output logic internal_osc_freq_select,
   output logic watchdog_enable,
   output logic watchdog_uses_own_osc,
   output logic ext_reset_pin_enable,
   output logic program_memory_protect,
   output logic data_flash_protect,
   output logic shared_pin_as_input,
   output logic device_reset,
   output logic sleeping,
   output logic wake_event
);

   // ------------------------------------------------------------------------
   // Captured configuration
   // ------------------------------------------------------------------------
   logic [`CWD_WORD_W-1:0] device_configuration_word;
   logic captured;
   logic pin_sync;
   logic [PIN_W-1:0] pins_sync;
   logic [PIN_W-1:0] pins_last;
   logic wdt_sync;
   logic wdt_last;
   cwd_state_t state;
   cwd_state_t next_state;
   logic [31:0] hold_count;
   logic [31:0] hold_target;
   logic ext_reset_high;
   logic pin_change;
   logic wdt_rise;
   logic sleep_req;
   logic [1:0] wake_cause;

   // The word is taken once, on the first clock after reset, and then frozen so
   // that a disturbed flash read later on cannot change the clock or protection.
   always_ff @(posedge clk) begin
      if (rst) begin
         device_configuration_word <= `CWD_CONFIG_RESET;
         captured <= 1'b0;
      end else if (!captured) begin
         device_configuration_word <= nv_config_word; // [RULE_14] [RULE_11]
         device_configuration_word[`CWD_UNIMPL_BIT] <= 1'b1; // [RULE_10]
         captured <= 1'b1;
      end
   end

   // ------------------------------------------------------------------------
   // Decoded controls
   // ------------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         oscillator_select <= 2'h3;
         internal_osc_freq_select <= 1'b1;
         watchdog_enable <= 1'b1;
         ext_reset_pin_enable <= 1'b1;
         program_memory_protect <= 1'b0;
         data_flash_protect <= 1'b0;
         shared_pin_as_input <= 1'b0;
      end else begin
         oscillator_select <= device_configuration_word[`CWD_OSC_HI:`CWD_OSC_LO]; // [RULE_01]
         internal_osc_freq_select <= device_configuration_word[`CWD_FREQ_BIT]; // [RULE_06]
         watchdog_enable <= device_configuration_word[`CWD_WDT_BIT]; // [RULE_04]
         ext_reset_pin_enable <= device_configuration_word[`CWD_RST_PIN_BIT]; // [RULE_07]
         shared_pin_as_input <= !device_configuration_word[`CWD_RST_PIN_BIT]; // [RULE_07]
         program_memory_protect <= !device_configuration_word[`CWD_PROG_PROT_BIT]; // [RULE_08]
         data_flash_protect <= !device_configuration_word[`CWD_DATA_PROT_BIT]; // [RULE_09]
      end
   end

   // The watchdog clock is never taken from the selected system source.
   assign watchdog_uses_own_osc = 1'b1; // [RULE_05]

   // ------------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------------
   cwd_sync #(.RESET_VAL(1'b0)) u_sync_rst_pin (
      .clk(clk),
      .rst(rst),
      .d(shared_input_pin),
      .q(pin_sync)
   );

   cwd_sync #(.RESET_VAL(1'b0)) u_sync_wdt (
      .clk(clk),
      .rst(rst),
      .d(watchdog_timeout),
      .q(wdt_sync)
   );

   genvar gi;
   generate
      for (gi = 0; gi < PIN_W; gi++) begin : g_pin_sync
         cwd_sync #(.RESET_VAL(1'b0)) u_sync (
            .clk(clk),
            .rst(rst),
            .d(input_pins[gi]),
            .q(pins_sync[gi])
         );
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (rst) begin
         pins_last <= '0;
         wdt_last <= 1'b0;
      end else begin
         pins_last <= pins_sync;
         wdt_last <= wdt_sync;
      end
   end

   // With the pin given over to general input the reset is tied inactive.
   assign ext_reset_high = ext_reset_pin_enable ? pin_sync : 1'b1; // [RULE_07]
   assign pin_change = (pins_sync != pins_last);
   assign wdt_rise = wdt_sync && !wdt_last && watchdog_enable;

   // ------------------------------------------------------------------------
   // Reset hold timer and sleep
   // ------------------------------------------------------------------------
   always_comb begin
      hold_target = 32'(HOLD_SHORT_CYC); // [RULE_03]
      if (oscillator_select == cwd_osc_low_power_crystal_mode ||
          oscillator_select == cwd_osc_crystal_resonator_mode) begin
         hold_target = 32'(HOLD_LONG_CYC); // [RULE_02]
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         cwd_st_wait_pin: begin
            if (captured && ext_reset_high) begin
               next_state = cwd_st_count; // [RULE_13]
            end
         end
         cwd_st_count: begin
            if (!ext_reset_high) begin
               next_state = cwd_st_wait_pin;
            end else if (hold_count >= hold_target - 32'h1) begin
               next_state = cwd_st_run; // [RULE_13]
            end
         end
         cwd_st_run: begin
            if (!ext_reset_high) begin
               next_state = cwd_st_wait_pin;
            end else if (sleep_req) begin
               next_state = cwd_st_sleep;
            end
         end
         cwd_st_sleep: begin
            if (!ext_reset_high) begin
               next_state = cwd_st_wait_pin;
            end else if (pin_change || wdt_rise) begin
               next_state = cwd_st_run; // [RULE_12]
            end
         end
         default: begin
            next_state = cwd_st_wait_pin;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= cwd_st_wait_pin;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || state != cwd_st_count) begin
         hold_count <= 32'h0;
      end else begin
         hold_count <= hold_count + 32'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         device_reset <= 1'b1;
         sleeping <= 1'b0;
         wake_event <= 1'b0;
      end else begin
         device_reset <= (next_state == cwd_st_wait_pin) || (next_state == cwd_st_count);
         sleeping <= (next_state == cwd_st_sleep);
         wake_event <= (state == cwd_st_sleep) && (next_state == cwd_st_run); // [RULE_12]
      end
   end

   // Wake cause is sticky; a new wake wins over a software clear in the same cycle.
   always_ff @(posedge clk) begin
      if (rst) begin
         wake_cause <= 2'h0;
      end else if (state == cwd_st_sleep && next_state == cwd_st_run) begin
         wake_cause <= {wdt_rise, pin_change && !wdt_rise};
      end else if (avs_write && !avs_waitrequest && avs_address == `CWD_ADDR_WAKE) begin
         wake_cause <= wake_cause & ~avs_writedata[1:0];
      end
   end

   // ------------------------------------------------------------------------
   // Avalon-MM slave
   // ------------------------------------------------------------------------
   logic ack;

   // One wait state per access: the answer comes at the second edge.
   always_ff @(posedge clk) begin
      if (rst) begin
         ack <= 1'b0;
      end else begin
         ack <= (avs_read || avs_write) && !ack;
      end
   end

   assign avs_waitrequest = (avs_read || avs_write) && !ack;
   assign sleep_req = avs_write && ack && avs_address == `CWD_ADDR_CONTROL && avs_writedata[0];

   always_ff @(posedge clk) begin
      if (rst) begin
         avs_readdata <= 32'h0;
      end else if (avs_read && !ack) begin
         if (avs_address == `CWD_ADDR_CONFIG) begin
            avs_readdata <= {20'h0, device_configuration_word};
         end else if (avs_address == `CWD_ADDR_STATUS) begin
            avs_readdata <= {24'h0, state, sleeping, device_reset, watchdog_enable,
                             watchdog_uses_own_osc};
         end else if (avs_address == `CWD_ADDR_WAKE) begin
            avs_readdata <= {30'h0, wake_cause};
         end else begin
            avs_readdata <= 32'h0;
         end
      end
   end

endmodule

// [logic/cwd_defines.svh]
// Constants of the configuration word decoder: field positions, reset values and timing.
// Assumes a 40 MHz system clock; included by the decoder module only, not by the package or the synchroniser.
//
// What this block does
// [RULE_01] Two-bit field selects low-power crystal, crystal, internal oscillator or external RC.
// [RULE_02] Either crystal mode holds the device in reset for nominally 18 ms.
// [RULE_03] Internal oscillator or external RC modes shorten the reset hold to 1 ms.
// [RULE_04] Bit 2 enables the watchdog; nothing else can switch it off.
// [RULE_05] The watchdog runs from its own oscillator, not the system clock.
// [RULE_06] Bit 5 selects internal oscillator 8 MHz when 1, 4 MHz when 0.
// [RULE_07] Bit 4 at 1 makes shared pin the reset input; at 0 a plain input.
// [RULE_08] Bit 3 at 0 protects program memory; at 1 protection is off.
// [RULE_09] Bit 6 at 0 protects data flash; at 1 protection is off.
// [RULE_10] Bit 7 is unimplemented and always reads back as one.
// [RULE_11] The configuration word is 12 bits wide.
// [RULE_12] In sleep, a pin change or watchdog time-out wakes the device.
// [RULE_13] Reset timer starts once external reset input is high, then releases reset.
// [RULE_14] Decoded outputs are captured at power-up and held constant afterwards.
`ifndef CWD_DEFINES_SVH
`define CWD_DEFINES_SVH

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define CWD_WORD_W 12
`define CWD_OSC_LO 0
`define CWD_OSC_HI 1
`define CWD_WDT_BIT 2
`define CWD_PROG_PROT_BIT 3
`define CWD_RST_PIN_BIT 4
`define CWD_FREQ_BIT 5
`define CWD_DATA_PROT_BIT 6
`define CWD_UNIMPL_BIT 7

// ---------------------------------------------------------------------------
// Register bus map
// ---------------------------------------------------------------------------
`define CWD_ADDR_CONFIG 4'h0
`define CWD_ADDR_STATUS 4'h4
`define CWD_ADDR_CONTROL 4'h8
`define CWD_ADDR_WAKE 4'hc

// ---------------------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------------------
`define CWD_CONFIG_RESET 12'hfff
`define CWD_CLK_HZ 40000000
`define CWD_HOLD_LONG_US 18000
`define CWD_HOLD_SHORT_US 1000
`define CWD_HOLD_LONG_CYC ((`CWD_CLK_HZ / 1000000) * `CWD_HOLD_LONG_US)
`define CWD_HOLD_SHORT_CYC ((`CWD_CLK_HZ / 1000000) * `CWD_HOLD_SHORT_US)

`endif

// [logic/cwd_pkg.sv]
// Types shared by the configuration word decoder modules.
// Assumes nothing of its surroundings.
package cwd_pkg;

   typedef enum logic [1:0] {
      cwd_osc_low_power_crystal_mode = 2'h0,
      cwd_osc_crystal_resonator_mode = 2'h1,
      cwd_osc_internal_osc_mode = 2'h2,
      cwd_osc_external_rc_mode = 2'h3
   } cwd_osc_t;

   typedef enum logic [3:0] {
      cwd_st_wait_pin = 4'h1,
      cwd_st_count = 4'h2,
      cwd_st_run = 4'h4,
      cwd_st_sleep = 4'h8
   } cwd_state_t;

endpackage

// [logic/cwd_sync.sv]
// Two-flop synchroniser for a single level coming from outside the clock domain.
// Assumes a synchronous active-high reset on the destination clock.
`timescale 1ns/1ps
module cwd_sync #(
   parameter logic RESET_VAL = 1'b0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic d,
   output logic q
);

   logic meta;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta <= RESET_VAL;
         q <= RESET_VAL;
      end else begin
         meta <= d;
         q <= meta;
      end
   end

endmodule

// [verification/cwd_props.sv]
// Concurrent checks on the ports of the configuration word decoder.
// Assumes it is bound into cwd_config_decoder and that rst is synchronous, active high.
`timescale 1ns/1ps
module cwd_props #(
   parameter int HOLD_LONG_CYC = 40,
   parameter int HOLD_SHORT_CYC = 10,
   parameter int PIN_W = 6
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [11:0] nv_config_word,
   input wire logic shared_input_pin,
   input wire logic [PIN_W-1:0] input_pins,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic [1:0] oscillator_select,
   input wire logic internal_osc_freq_select,
   input wire logic watchdog_enable,
   input wire logic watchdog_uses_own_osc,
   input wire logic ext_reset_pin_enable,
   input wire logic program_memory_protect,
   input wire logic data_flash_protect,
   input wire logic shared_pin_as_input,
   input wire logic device_reset,
   input wire logic sleeping,
   input wire logic wake_event
);
   // ------------------------------------------------------------------
   // Own copy of the captured word and a hold counter
   // ------------------------------------------------------------------
   // The counter starts before the design's synchroniser does, so the bound is loose.
   logic [11:0] cap;
   logic [1:0] age;
   logic ok;
   int cnt;
   int hold;
   assign ok = age >= 2'h2;
   assign hold = cap[1] ? HOLD_SHORT_CYC : HOLD_LONG_CYC;
   always_ff @(posedge clk) begin
      if (rst) begin
         age <= 2'h0;
      end else if (age != 2'h3) begin
         age <= age + 2'h1;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         cap <= 12'hfff;
      end else if (age == 2'h0) begin
         cap <= nv_config_word;
      end
   end
   always_ff @(posedge clk) begin
      if (rst || !device_reset || (cap[4] && !shared_input_pin)) begin
         cnt <= 0;
      end else begin
         cnt <= cnt + 1;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_osc_decode: assert property (ok |-> oscillator_select == cap[1:0])
      else $error("oscillator select differs from word");
   a_freq_decode: assert property (ok |-> internal_osc_freq_select == cap[5])
      else $error("frequency select differs from word");
   a_wdt_decode: assert property (ok |-> watchdog_enable == cap[2])
      else $error("watchdog enable differs from word");
   a_pin_role: assert property (ok |-> {ext_reset_pin_enable, shared_pin_as_input} == {cap[4], !cap[4]})
      else $error("shared pin role differs from word");
   a_prot_decode: assert property (ok |-> {program_memory_protect, data_flash_protect} == ~{cap[3], cap[6]})
      else $error("protection differs from word");
   a_own_osc: assert property (watchdog_uses_own_osc)
      else $error("watchdog not on own oscillator");
   a_hold_time: assert property ($fell(device_reset) |-> cnt >= hold - 2 && cnt <= hold + 6)
      else $error("reset hold length wrong");
   a_pin_holds: assert property ((ext_reset_pin_enable && !shared_input_pin) [*6] |-> device_reset)
      else $error("reset released while pin low");
   a_bus_wait: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("bus wait state wrong");
   a_wake_pulse: assert property (wake_event |-> !sleeping ##1 !wake_event)
      else $error("wake pulse wrong");
   a_pin_wake: assert property (sleeping && !$stable(input_pins) |-> ##[1:5] wake_event)
      else $error("pin change did not wake");
   c_release: cover property ($fell(device_reset));
   c_wake: cover property (wake_event);
   c_bus: cover property (avs_read && !avs_waitrequest);
endmodule
bind cwd_config_decoder cwd_props #(.HOLD_LONG_CYC(HOLD_LONG_CYC), .HOLD_SHORT_CYC(HOLD_SHORT_CYC),
   .PIN_W(PIN_W)) u_props (.*);

// [verification/config_word_decoder_bench.sv]
// Self-checking bench for the configuration word decoder.
// Assumes the design and cwd_props are compiled alongside it.
`timescale 1ns/1ps
module config_word_decoder_bench
   import cwd_pkg::*;
;
   localparam int HL = 40;
   localparam int HS = 10;
   logic clk = 0, rst = 1, shared_input_pin = 1, watchdog_timeout = 0;
   logic avs_read = 0, avs_write = 0, avs_waitrequest;
   logic [11:0] nv_config_word = 12'hfff;
   logic [5:0] input_pins = 6'h00;
   logic [3:0] avs_address = 4'h0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rdat;
   logic [1:0] oscillator_select;
   logic internal_osc_freq_select, watchdog_enable, watchdog_uses_own_osc;
   logic ext_reset_pin_enable, program_memory_protect, data_flash_protect;
   logic shared_pin_as_input, device_reset, sleeping, wake_event;
   int miscompares = 0, num_checks = 0;
   cwd_config_decoder #(.HOLD_LONG_CYC(HL), .HOLD_SHORT_CYC(HS)) dut (.*);
   initial forever #12.5 clk = ~clk;
   // ------------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------------
   // Inputs change by non-blocking assignment right after the edge; outputs read right
   // after the edge still hold the values the design sampled at that edge.
   task automatic tick();
      @(posedge clk);
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic give_up();
      miscompares++;
      complete_run();
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= v;
      avs_read <= !w;
      avs_write <= w;
      do begin
         tick();
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      if (n >= 20) give_up();
      rdat = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      tick();
   endtask
   task automatic start(input logic [11:0] w);
      rst <= 1'b1;
      nv_config_word <= w;
      repeat (6) tick();
      rst <= 1'b0;
   endtask
   task automatic wait_rel(input int h);
      int n;
      n = 0;
      while (device_reset !== 1'b0 && n < 2000) begin
         tick();
         n++;
      end
      if (n >= 2000) give_up();
      check(32'(n >= h && n <= h + 10), 32'h1);
   endtask
   task automatic wake();
      int n;
      n = 0;
      while (wake_event !== 1'b1 && n < 10) begin
         tick();
         n++;
      end
      if (n >= 10) give_up();
      check(32'(wake_event), 32'h1);
      tick();
      check(32'(sleeping), 32'h0);
   endtask
   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic test_decode();
      logic [11:0] w [4] = '{12'h07c, 12'h001, 12'h056, 12'ha2b};
      for (int i = 0; i < 4; i++) begin
         start(w[i]);
         wait_rel(w[i][1] ? HS : HL);
         check(32'(oscillator_select), 32'(w[i][1:0]));
         check(32'(internal_osc_freq_select), 32'(w[i][5]));
         check(32'(watchdog_enable), 32'(w[i][2]));
         check(32'(watchdog_uses_own_osc), 32'h1);
         check(32'({ext_reset_pin_enable, shared_pin_as_input}), 32'({w[i][4], !w[i][4]}));
         check(32'({program_memory_protect, data_flash_protect}), 32'({!w[i][3], !w[i][6]}));
         bus(1'b0, 4'h0, 32'h0);
         check(rdat, 32'(w[i] | 12'h080));
      end
      $display("decode test done");
   endtask
   task automatic test_pin();
      shared_input_pin <= 1'b0;
      start(12'h002);
      wait_rel(HS);
      start(12'h010);
      repeat (60) tick();
      check(32'(device_reset), 32'h1);
      shared_input_pin <= 1'b1;
      wait_rel(HL);
      shared_input_pin <= 1'b0;
      repeat (6) tick();
      check(32'(device_reset), 32'h1);
      shared_input_pin <= 1'b1;
      wait_rel(HL);
      $display("pin test done");
   endtask
   task automatic test_static();
      nv_config_word <= 12'hfff;
      bus(1'b1, 4'h0, 32'hfff);
      check(32'({oscillator_select, ext_reset_pin_enable}), 32'h1);
      bus(1'b0, 4'h0, 32'h0);
      check(rdat, 32'h090);
      bus(1'b0, 4'h2, 32'h0);
      check(rdat, 32'h0);
      bus(1'b0, 4'h4, 32'h0);
      check(rdat, 32'h41);
      $display("static test done");
   endtask
   task automatic test_sleep();
      bus(1'b1, 4'h8, 32'h1);
      tick();
      check(32'(sleeping), 32'h1);
      watchdog_timeout <= 1'b1;
      repeat (8) tick();
      check(32'(sleeping), 32'h1);
      input_pins <= ~input_pins;
      wake();
      bus(1'b0, 4'hc, 32'h0);
      check(rdat, 32'h1);
      bus(1'b1, 4'hc, 32'h1);
      bus(1'b0, 4'hc, 32'h0);
      check(rdat, 32'h0);
      watchdog_timeout <= 1'b0;
      start(12'h014);
      wait_rel(HL);
      bus(1'b1, 4'h8, 32'h1);
      watchdog_timeout <= 1'b1;
      wake();
      bus(1'b0, 4'hc, 32'h0);
      check(rdat, 32'h2);
      watchdog_timeout <= 1'b0;
      $display("sleep test done");
   endtask
   initial begin
      test_decode();
      test_pin();
      test_static();
      test_sleep();
      complete_run();
   end
endmodule
